// [src/antenna_irq_pkg.sv]
// Package for the antenna select and radio event enable register bank.
// Assumes an AHB-Lite slave with 32-bit data, one register per aligned word.
package antenna_irq_pkg;

    // Printed offsets are not all multiples of four: each is a register index, byte address is four times it
    localparam logic [9:0] IDX_STATIC_ANTENNA_FIELD = 10'h14D;
    localparam logic [9:0] IDX_EV_EN = 10'h14E;
    localparam logic [9:0] IDX_EV_STAT = 10'h14F;
    localparam logic [9:0] IDX_EV_EN_EXT = 10'h0BE;
    localparam logic [9:0] IDX_EV_STAT_EXT = 10'h0BF;

    // Antenna control fields
    localparam int ANT_FLAG_BIT = 7;
    localparam int AUTO_EN_BIT = 3;
    localparam int DRIVE_EN_BIT = 2;
    localparam int STATIC_LSB = 0;
    localparam logic [1:0] STATIC_RESET = 2'h3;
    localparam logic [1:0] STATIC_ANT1 = 2'h1;
    localparam logic [1:0] STATIC_ANT0 = 2'h2;

    // Event layout: first set at bits 7:0, second set at bits 4:0
    localparam logic [7:0] EV_EN_RESET = 8'h00;
    localparam logic [4:0] EV_EXT_RESET = 5'h00;
    localparam int EV_EXT_W = 5;

    typedef struct packed {
        logic [1:0] staticAntenna;
        logic autoSelectEnable;
        logic switchDriveEnable;
        logic autoAntenna;
        logic [7:0] eventEnable;
        logic [4:0] eventEnableExt;
        logic [7:0] eventStatus;
        logic [4:0] eventStatusExt;
        logic dataPhase;
        logic dataWrite;
        logic [9:0] dataIndex;
        logic [31:0] readData;
    } bank_state_t;

    // Radio side inputs, all same-clock pulses or levels
    typedef struct packed {
        logic headerSearchStart;
        logic autoChoiceValid;
        logic autoChoice;
        logic inReceive;
        logic [7:0] events;
        logic [4:0] eventsExt;
        logic [7:0] serviceAck;
        logic [4:0] serviceAckExt;
    } radio_in_t;

    // Switch pin pair: out and output enable for each
    typedef struct packed {
        logic pinAOut;
        logic pinAOe;
        logic pinBOut;
        logic pinBOe;
    } switch_pins_t;

endpackage

// [src/antenna_irq_bank.sv]
// Antenna select control and radio event enable/status registers behind an AHB-Lite slave.
// Assumes radio inputs are on mclk; gpio bank values come from port logic on mclk.
//
// Summary of operation
// - Bit 7 of antenna control reads the antenna in use, 0 or 1.
// - Antenna follows last automatic choice when auto enabled, else static field.
// - With auto-select bit 3 set, antenna chosen during header search.
// - Auto choice held until new search, receive exit, or static field write.
// - Drive enable bit 2 makes both pins outputs with complementary antenna pair.
// - Pins stay driven in every transceiver state while drive enabled.
// - Drive enable 0 returns pins to general-purpose output and direction registers.
// - Static field: 1 antenna 1 A low B high, 2 antenna 0 A high B low, reset 3.
// - Each enable bit passes its interrupt source only when set.
// - All enable bits clear after reset.
// - First mask: 7 wake,6 tx end,5 addr match,4 ED done,3 rx end,2 rx start,1 unlock,0 lock.
// - Second mask: filter 3..0 match enables bits 4..1, tx start bit 0, 7:5 zero.
// - Status bit clears on write of one or on service acknowledge.
`timescale 1ns/1ns
`default_nettype none

module antenna_irq_bank
(
    input wire logic mclk,
    input wire logic rst_n,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic hresp,
    output logic [31:0] hrdata,
    input wire antenna_irq_pkg::radio_in_t radioIn,
    input wire logic gpioOutBankF,
    input wire logic gpioDirBankF,
    input wire logic gpioOutBankG,
    input wire logic gpioDirBankG,
    output antenna_irq_pkg::switch_pins_t switchPins,
    output logic currentAntennaFlag,
    output logic irq
);
    import antenna_irq_pkg::*;

    bank_state_t state_r;
    bank_state_t state_nxt;
    logic addrPhase;
    logic wrCtrl;
    logic wrEvEn;
    logic wrEvStat;
    logic wrEvEnExt;
    logic wrEvStatExt;
    logic antennaSel;
    // Antenna as it will stand after this edge, so a read sees a write in the data phase just before it
    logic antennaNext;
    // Full-width result of the sticky update for the second status set; only its low bits are kept
    logic [7:0] statusExtWide;

    // Bus timing in short:
    // the address phase is taken at the edge where hsel, hready and a NONSEQ or SEQ transfer (htrans[1]) meet;
    // the index and direction are held in the state for one cycle, the data phase;
    // a write lands at the end of that data phase, with hwdata as it stands then;
    // read data is registered at the address-phase edge and stands for the data phase.
    // Since the slave never inserts wait states, back-to-back transfers are fine,
    // but a read right behind a write must see the new value: the read mux therefore
    // looks at the next state, not at the registered one.

    // Word index from byte address; low two bits ignored since only word transfers occur
    function automatic logic [9:0] wordIndex(input logic [31:0] a);
        return a[11:2];
    endfunction

    // Sticky status update: a new event beats a clear in the same cycle
    function automatic logic [7:0] stickyNext(input logic [7:0] cur, input logic [7:0] set,
                                              input logic [7:0] clr);
        return (cur & ~clr) | set;
    endfunction

    // Static field decode: only code 1 names antenna 1; reserved 0 and default 3 fall to antenna 0
    function automatic logic antennaSelStatic(input logic [1:0] f);
        return (f == STATIC_ANT1);
    endfunction

    // Register read decode; unmapped words read as zero and the reserved bits read as zero
    function automatic logic [31:0] readWord(input logic [9:0] idx, input bank_state_t s, input logic ant);
        logic [31:0] w;
        w = 32'h0000_0000;
        case (idx)
            IDX_STATIC_ANTENNA_FIELD:
                w = {24'h00_0000, ant, 3'h0, s.autoSelectEnable, s.switchDriveEnable, s.staticAntenna};
            IDX_EV_EN:
                w = {24'h00_0000, s.eventEnable};
            IDX_EV_STAT:
                w = {24'h00_0000, s.eventStatus};
            IDX_EV_EN_EXT:
                w = {27'h000_0000, s.eventEnableExt};
            IDX_EV_STAT_EXT:
                w = {27'h000_0000, s.eventStatusExt};
            default:
                w = 32'h0000_0000;
        endcase
        return w;
    endfunction

    // Antenna in use: auto choice when enabled, else decoded static field
    always_comb
    begin
        if (state_r.autoSelectEnable)
            antennaSel = state_r.autoAntenna;
        else
            antennaSel = (state_r.staticAntenna == STATIC_ANT1);
    end

    assign addrPhase = hsel && hready && htrans[1];
    assign wrCtrl = state_r.dataPhase && state_r.dataWrite && state_r.dataIndex == IDX_STATIC_ANTENNA_FIELD;
    assign wrEvEn = state_r.dataPhase && state_r.dataWrite && state_r.dataIndex == IDX_EV_EN;
    assign wrEvStat = state_r.dataPhase && state_r.dataWrite && state_r.dataIndex == IDX_EV_STAT;
    assign wrEvEnExt = state_r.dataPhase && state_r.dataWrite && state_r.dataIndex == IDX_EV_EN_EXT;
    assign wrEvStatExt = state_r.dataPhase && state_r.dataWrite && state_r.dataIndex == IDX_EV_STAT_EXT;

    // Next state: bus capture, register writes, antenna choice, event flags, read data
    always_comb
    begin
        state_nxt = state_r;
        statusExtWide = 8'h00;
        antennaNext = 1'b0;
        // Capture the address phase; the write itself lands one cycle later with hwdata
        state_nxt.dataPhase = addrPhase;
        if (addrPhase)
        begin
            state_nxt.dataWrite = hwrite;
            state_nxt.dataIndex = wordIndex(haddr);
        end
        // Control register takes bits 3:0 of the word; the antenna flag bit is read-only
        if (wrCtrl)
        begin
            state_nxt.staticAntenna = hwdata[STATIC_LSB +: 2];
            state_nxt.autoSelectEnable = hwdata[AUTO_EN_BIT];
            state_nxt.switchDriveEnable = hwdata[DRIVE_EN_BIT];
        end
        // Enable masks; reserved upper bits of the second mask are never stored
        if (wrEvEn)
        begin
            state_nxt.eventEnable = hwdata[7:0];
        end
        if (wrEvEnExt)
        begin
            state_nxt.eventEnableExt = hwdata[EV_EXT_W-1:0];
        end
        // Auto choice: a static write or leaving receive reverts to the static antenna,
        // and a new search restarts from it until the algorithm picks again
        if (wrCtrl || !radioIn.inReceive || radioIn.headerSearchStart)
        begin
            state_nxt.autoAntenna = antennaSelStatic(wrCtrl ? hwdata[STATIC_LSB +: 2] :
                                                     state_r.staticAntenna);
        end
        // A pick is ignored in a control write cycle, so software always has the last word
        if (state_r.autoSelectEnable && radioIn.inReceive && radioIn.autoChoiceValid && !wrCtrl)
        begin
            state_nxt.autoAntenna = radioIn.autoChoice;
        end
        // Sticky status: service acknowledge and write-one clear, a new event wins the tie
        state_nxt.eventStatus = stickyNext(state_r.eventStatus, radioIn.events,
            radioIn.serviceAck | (wrEvStat ? hwdata[7:0] : 8'h00));
        statusExtWide = stickyNext({3'h0, state_r.eventStatusExt}, {3'h0, radioIn.eventsExt},
            {3'h0, radioIn.serviceAckExt | (wrEvStatExt ? hwdata[EV_EXT_W-1:0] : 5'h00)});
        state_nxt.eventStatusExt = statusExtWide[EV_EXT_W-1:0];
        // Read data comes from the next state: a pipelined read behind a write sees the new word
        antennaNext = state_nxt.autoSelectEnable ? state_nxt.autoAntenna :
                      antennaSelStatic(state_nxt.staticAntenna);
        state_nxt.readData = 32'h0000_0000;
        if (addrPhase && !hwrite)
        begin
            state_nxt.readData = readWord(wordIndex(haddr), state_nxt, antennaNext);
        end
    end

    // Register the whole state; reset restores defaults with every enable cleared
    always_ff @(posedge mclk)
    begin
        if (!rst_n)
        begin
            state_r <= '0;
            state_r.staticAntenna <= STATIC_RESET;
            state_r.eventEnable <= EV_EN_RESET;
            state_r.eventEnableExt <= EV_EXT_RESET;
        end
        else
        begin
            state_r <= state_nxt;
        end
    end

    // Zero-wait slave, always OKAY
    assign hreadyout = 1'b1;
    assign hresp = 1'b0;
    assign hrdata = state_r.readData;

    // Switch pins: driven as complementary pair in any state while enabled,
    // otherwise handed back to the general-purpose port banks.
    // The block does not look at the transceiver state here on purpose: drive stays on
    // in sleep too, and it is up to software to switch it off to save switch leakage.
    always_comb
    begin
        if (state_r.switchDriveEnable)
        begin
            switchPins.pinAOut = ~antennaSel;
            switchPins.pinBOut = antennaSel;
            switchPins.pinAOe = 1'b1;
            switchPins.pinBOe = 1'b1;
        end
        else
        begin
            switchPins.pinAOut = gpioOutBankF;
            switchPins.pinAOe = gpioDirBankF;
            switchPins.pinBOut = gpioOutBankG;
            switchPins.pinBOe = gpioDirBankG;
        end
    end

    assign currentAntennaFlag = antennaSel;

    // Level interrupt while any enabled status bit is pending
    assign irq = |(state_r.eventStatus & state_r.eventEnable) |
                 |(state_r.eventStatusExt & state_r.eventEnableExt);

endmodule

`default_nettype wire

// [bench/antenna_irq_bank_sva.sv]
// Port-level checks of the antenna select and radio event bank.
// Assumes it is bound onto antenna_irq_bank, one mclk domain.
`timescale 1ns/1ns
`default_nettype none
module antenna_irq_bank_sva
(
    input wire logic mclk,
    input wire logic rst_n,
    input wire logic hwrite,
    input wire antenna_irq_pkg::radio_in_t radioIn,
    input wire logic gpioOutBankF,
    input wire logic gpioDirBankF,
    input wire logic gpioOutBankG,
    input wire logic gpioDirBankG,
    input wire antenna_irq_pkg::switch_pins_t switchPins,
    input wire logic currentAntennaFlag,
    input wire logic irq
);
    import antenna_irq_pkg::*;
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!rst_n);
    // Pin A driven against its gpio direction means the switch drive owns both pins
    property p_pair; switchPins.pinAOe && !gpioDirBankF |-> switchPins.pinBOe; endproperty
    a_pair: assert property (p_pair) else $error("pin B not driven");
    property p_compl; switchPins.pinAOe && !gpioDirBankF |-> switchPins.pinAOut != switchPins.pinBOut
        && currentAntennaFlag == switchPins.pinBOut; endproperty
    a_compl: assert property (p_compl) else $error("pins not complementary");
    property p_relA; !switchPins.pinAOe |-> !gpioDirBankF && switchPins.pinAOut == gpioOutBankF; endproperty
    a_relA: assert property (p_relA) else $error("pin A not released");
    property p_relB; !switchPins.pinBOe |-> !gpioDirBankG && switchPins.pinBOut == gpioOutBankG; endproperty
    a_relB: assert property (p_relB) else $error("pin B not released");
    property p_reset; $rose(rst_n) |-> !irq && !currentAntennaFlag; endproperty
    a_reset: assert property (p_reset) else $error("bad state after reset");
    // A request only rises after an event or a register write
    property p_irqRise; $rose(irq) |-> $past(|radioIn.events) || $past(|radioIn.eventsExt) || $past(hwrite, 2); endproperty
    a_irqRise: assert property (p_irqRise) else $error("irq rose without cause");
    property p_irqFall; $fell(irq) |-> $past(|radioIn.serviceAck) || $past(|radioIn.serviceAckExt) || $past(hwrite, 2);
    endproperty
    a_irqFall: assert property (p_irqFall) else $error("irq fell without clear");
    // Antenna choice holds unless a choice, a search, a receive exit or a write
    property p_hold; $changed(currentAntennaFlag) |-> $past(radioIn.autoChoiceValid) || $past(radioIn.headerSearchStart)
        || ($past(radioIn.inReceive, 2) && !$past(radioIn.inReceive)) || $past(hwrite, 2); endproperty
    a_hold: assert property (p_hold) else $error("antenna changed without cause");
    c_irq: cover property ($rose(irq));
    c_ant1: cover property ($rose(currentAntennaFlag));
    c_drive: cover property (switchPins.pinAOe && !gpioDirBankF);
endmodule
bind antenna_irq_bank antenna_irq_bank_sva antenna_irq_bank_sva_inst (.*);
`default_nettype wire

// [bench/antenna_switch_model.sv]
// Model of the external RF switch hanging on the two antenna pins.
// Assumes oe high means the bank drives the pin.
`timescale 1ns/1ns
`default_nettype none
module antenna_switch_model
(
    input wire antenna_irq_pkg::switch_pins_t switchPins,
    output logic antSelected,
    output logic pairFault
);
    import antenna_irq_pkg::*;
    // Antenna 1 only for A low, B high; anything else lands on antenna 0
    assign antSelected = switchPins.pinAOe && switchPins.pinBOe && !switchPins.pinAOut && switchPins.pinBOut;
    // Equal driven levels leave the switch in an undefined path
    assign pairFault = switchPins.pinAOe && switchPins.pinBOe && switchPins.pinAOut == switchPins.pinBOut;
endmodule
`default_nettype wire

// [bench/antenna_select_irq_enable_tb_top.sv]
// Self-checking bench for the antenna select and radio event bank.
// Assumes the bank is the only AHB-Lite slave; hready loops back from hreadyout.
`timescale 1ns/1ns
`default_nettype none
module antenna_select_irq_enable_tb_top;
    import antenna_irq_pkg::*;
    logic mclk = 1'b0;
    logic rst_n = 1'b0;
    logic [31:0] haddr = 32'h0;
    logic [1:0] htrans = 2'h0;
    logic hwrite = 1'b0;
    logic [31:0] hwdata = 32'h0;
    logic [31:0] hrdata, rd, mask;
    logic hreadyout, hresp, currentAntennaFlag, irq, antSelected, pairFault;
    logic [3:0] gpio = 4'h0;
    logic [9:0] idxTab [6] = '{IDX_STATIC_ANTENNA_FIELD, IDX_EV_EN, IDX_EV_EN_EXT, IDX_EV_STAT, IDX_EV_STAT_EXT, 10'h000};
    logic [31:0] rstTab [6] = '{32'h3, 32'h0, 32'h0, 32'h0, 32'h0, 32'h0};
    radio_in_t radioIn = '0;
    radio_in_t r;
    switch_pins_t switchPins;
    integer seed = 32'hF8845016;
    int failures = 0;
    int check_count = 0;
    int k;
    antenna_irq_bank antenna_irq_bank_inst (.mclk(mclk), .rst_n(rst_n), .hsel(1'b1), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
        .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .radioIn(radioIn), .gpioOutBankF(gpio[3]),
        .gpioDirBankF(gpio[2]), .gpioOutBankG(gpio[1]), .gpioDirBankG(gpio[0]), .switchPins(switchPins),
        .currentAntennaFlag(currentAntennaFlag), .irq(irq));
    antenna_switch_model antenna_switch_model_inst (.switchPins(switchPins), .antSelected(antSelected),
        .pairFault(pairFault));
    initial forever #5 mclk = ~mclk;
    task automatic chk(input logic [31:0] e, input logic [31:0] g);
        check_count++;
        if (g !== e)
        begin
            failures++;
            $display("FAIL t=%0t exp=%h got=%h", $time, e, g);
        end
    endtask
    // Single-bit results: flags, pins and the interrupt line
    task automatic chkBit(input logic e, input logic g);
        check_count++;
        if (g !== e)
        begin
            failures++;
            $display("FAIL t=%0t exp=%h got=%h", $time, e, g);
        end
    endtask
    // One single-word transfer; a spare edge first keeps drives one per time step
    task automatic bus(input logic w, input logic [9:0] idx, input logic [31:0] d);
        @(posedge mclk);
        haddr <= {20'h00000, idx, 2'h0};
        htrans <= 2'h2;
        hwrite <= w;
        do @(posedge mclk); while (hreadyout !== 1'b1);
        htrans <= 2'h0;
        hwdata <= d;
        do @(posedge mclk); while (hreadyout !== 1'b1);
        rd = hrdata;
    endtask
    // Radio inputs for one cycle; receive level is kept afterwards
    task automatic ev(input radio_in_t v);
        radio_in_t h;
        h = '0;
        h.inReceive = v.inReceive;
        @(posedge mclk);
        radioIn <= v;
        @(posedge mclk);
        radioIn <= h;
        #1;
    endtask
    task automatic finish_test;
        $display("checks %0d failures %0d", check_count, failures);
        if (failures == 0 && check_count > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask
    initial
    begin
        #100000;
        failures++;
        finish_test();
    end
    initial
    begin
        repeat (3) @(posedge mclk);
        rst_n <= 1'b1;
        foreach (idxTab[i])
        begin
            bus(1'b0, idxTab[i], 32'h0);
            chk(rstTab[i], rd);
            chkBit(1'b0, hresp);
        end
        mask = $random(seed);
        bus(1'b1, IDX_EV_EN, mask);
        bus(1'b0, IDX_EV_EN, 32'h0);
        chk({24'h0, mask[7:0]}, rd);
        bus(1'b1, IDX_EV_EN_EXT, mask);
        bus(1'b0, IDX_EV_EN_EXT, 32'h0);
        chk({27'h0, mask[4:0]}, rd);
        $display("test registers done");
        // Each first-set source: masked event stays quiet, enabling raises, write one clears; one random second-set source is cleared by service acknowledge
        for (int i = 0; i < 8; i++)
        begin
            bus(1'b1, IDX_EV_EN, ~(32'h1 << i));
            r = '0;
            r.events = 8'h1 << i;
            ev(r);
            chkBit(1'b0, irq);
            bus(1'b0, IDX_EV_STAT, 32'h0);
            chk(32'h1 << i, rd);
            bus(1'b1, IDX_EV_EN, 32'hFF);
            #1;
            chkBit(1'b1, irq);
            bus(1'b1, IDX_EV_STAT, 32'h1 << i);
            #1;
            chkBit(1'b0, irq);
        end
        k = {$random(seed)} % 5;
        bus(1'b1, IDX_EV_EN_EXT, 32'h1F ^ (32'h1 << k));
        r = '0;
        r.eventsExt = 5'h1 << k;
        ev(r);
        chkBit(1'b0, irq);
        bus(1'b0, IDX_EV_STAT_EXT, 32'h0);
        chk(32'h1 << k, rd);
        bus(1'b1, IDX_EV_EN_EXT, 32'h1F);
        #1;
        chkBit(1'b1, irq);
        r = '0;
        r.serviceAckExt = 5'h1 << k;
        ev(r);
        chkBit(1'b0, irq);
        $display("test events done");
        // Static field with drive on, including the reserved and default codes
        for (int s = 0; s < 4; s++)
        begin
            bus(1'b1, IDX_STATIC_ANTENNA_FIELD, 32'h4 | s);
            bus(1'b0, IDX_STATIC_ANTENNA_FIELD, 32'h0);
            chk({24'h0, s == 1, 4'h0, 1'b1, 2'(s)}, rd);
            chkBit(s == 1, antSelected);
            chkBit(1'b0, pairFault);
        end
        bus(1'b1, IDX_STATIC_ANTENNA_FIELD, 32'hE);
        r = '0;
        r.inReceive = 1'b1;
        r.autoChoiceValid = 1'b1;
        r.autoChoice = 1'b1;
        ev(r);
        chkBit(1'b1, antSelected);
        r.autoChoiceValid = 1'b0;
        r.headerSearchStart = 1'b1;
        ev(r);
        chkBit(1'b0, currentAntennaFlag);
        $display("test antenna done");
        // Drive off hands the pins back to the port registers
        bus(1'b1, IDX_STATIC_ANTENNA_FIELD, 32'h3);
        repeat (4)
        begin
            gpio <= 4'($random(seed));
            #10;
            chk({28'h0, gpio}, {28'h0, switchPins});
        end
        $display("test release done");
        finish_test();
    end
endmodule
`default_nettype wire
